//--- include/rtcca_pkg.sv
// constants for the calendar, freeze and alarm-compare block
package rtcca_pkg;
  // register offsets
  localparam logic [7:0] ADDR_MONTH  = 8'h08;
  localparam logic [7:0] ADDR_YEAR   = 8'h09;
  localparam logic [7:0] ADDR_SEC_AL = 8'h0a;
  localparam logic [7:0] ADDR_MIN_AL = 8'h0b;
  localparam logic [7:0] ADDR_HR_AL  = 8'h0c;
  // implemented-bit masks, unimplemented bits read zero
  localparam logic [7:0] MASK_MONTH  = 8'h1f;
  localparam logic [7:0] MASK_YEAR   = 8'hff;
  localparam logic [7:0] MASK_SEC_AL = 8'hff;
  localparam logic [7:0] MASK_MIN_AL = 8'hff;
  localparam logic [7:0] MASK_HR_AL  = 8'hbf;
  // field positions
  localparam int DISABLE_BIT   = 7;
  localparam int AFTERNOON_BIT = 5;
  // value after reset of the match-disable bits
  localparam logic DISABLE_RST = 1'b1;
  // calendar limits in bcd
  localparam logic [7:0] MONTH_FIRST = 8'h01;
  localparam logic [7:0] MONTH_LAST  = 8'h12;
  localparam logic [7:0] MONTH_FEB   = 8'h02;
  localparam logic [7:0] YEAR_FIRST  = 8'h00;
  localparam logic [7:0] YEAR_LAST   = 8'h99;
  localparam logic [7:0] DAYS_28     = 8'h28;
  localparam logic [7:0] DAYS_29     = 8'h29;
  localparam logic [7:0] DAYS_30     = 8'h30;
  localparam logic [7:0] DAYS_31     = 8'h31;
  localparam logic [7:0] SEC_LAST    = 8'h59;
  localparam logic [7:0] HOUR24_LAST = 8'h23;
  localparam logic [7:0] HOUR12_LAST = 8'h12;
  localparam logic [3:0] UNITS_LAST  = 4'h9;
endpackage

//--- logic/rtcca_bcd_step.sv
// two-digit bcd incrementer with a wrap range
module rtcca_bcd_step (
  input  wire logic [7:0] cur,
  input  wire logic [7:0] lo,
  input  wire logic [7:0] hi,
  output logic      [7:0] nxt,
  output logic            wrap
);
  always_comb begin
    wrap = (cur == hi);
    if (cur == hi) begin
      nxt = lo;
    end else if (cur[3:0] >= rtcca_pkg::UNITS_LAST) begin
      nxt = {cur[7:4] + 4'h1, 4'h0};
    end else begin
      nxt = {cur[7:4], cur[3:0] + 4'h1};
    end
  end
endmodule

//--- logic/rtcca_top.sv
// month/year counters, access freeze and second/minute/hour alarm compare
//
// How it works
// - month stored bcd, bits 7-5 zero
// - months one to twelve, bcd in bits 4-0
// - year is two bcd digits 00-99
// - time and alarm values ignore reset
// - counters frozen while host access runs
// - one pending tick applied after access
// - enabled valid alarm fields compared to time
// - second alarm: disable bit7, bcd 00-59
// - minute alarm: disable bit7, bcd 00-59
// - hour alarm: disable bit7, bit6 unused
// - 12-hour alarm: bit5 afternoon, hours 1-12
// - 24-hour alarm: bits 5-4 tens, 0-23
// - hour format select picks alarm interpretation
// - unimplemented bits always read as zero
// - flag set on first full match, sticky
// - year divisible by four gives february 29
module rtcca_top (
  input  wire logic       CLOCK,
  input  wire logic       SRST,
  input  wire logic       TICK_1HZ,
  input  wire logic       ACCESS_BUSY,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic       REG_WR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_RD,
  input  wire logic       MONTH_CARRY,
  input  wire logic [7:0] SECOND_NOW,
  input  wire logic [7:0] MINUTE_NOW,
  input  wire logic [7:0] HOUR_NOW,
  input  wire logic       HOUR_12_MODE,
  input  wire logic       FLAG_CLEAR,
  output logic      [7:0] REG_RDATA,
  output logic            COUNT_EN,
  output logic      [7:0] DAYS_IN_MONTH,
  output logic            MATCH_FLAG
);
  // value fields carry no reset on purpose
  logic [4:0] month_q, month_d;
  logic [7:0] year_q, year_d;
  logic [6:0] sec_val_q, sec_val_d;
  logic [6:0] min_val_q, min_val_d;
  logic [5:0] hr_val_q, hr_val_d;
  // reset-bearing control state
  logic       second_match_disable_q, second_match_disable_d;
  logic       minute_match_disable_q, minute_match_disable_d;
  logic       hour_match_disable_q, hour_match_disable_d;
  logic       pending_q, pending_d;
  logic       count_en_q, count_en_d;
  logic       check_q, check_d;
  logic       match_flag_q, match_flag_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] days_q, days_d;

  logic [7:0] month_nxt;
  logic [7:0] year_nxt;
  logic       month_wrap;
  logic       year_wrap;
  logic       leap;
  logic       sec_ok, min_ok, hr_ok;
  logic       sec_hit, min_hit, hr_hit;
  logic       any_enabled;
  logic       full_match;

  rtcca_bcd_step u_month_step (
    .cur  ({3'h0, month_q}),
    .lo   (rtcca_pkg::MONTH_FIRST),
    .hi   (rtcca_pkg::MONTH_LAST),
    .nxt  (month_nxt),
    .wrap (month_wrap)
  );

  rtcca_bcd_step u_year_step (
    .cur  (year_q),
    .lo   (rtcca_pkg::YEAR_FIRST),
    .hi   (rtcca_pkg::YEAR_LAST),
    .nxt  (year_nxt),
    .wrap (year_wrap)
  );

  // freeze and pending tick
  always_comb begin
    pending_d  = pending_q;
    count_en_d = 1'b0;
    if (!ACCESS_BUSY && pending_q) begin
      count_en_d = 1'b1;
      pending_d  = 1'b0;
    end
    // a tick landing on the release cycle stays pending; a second tick
    // inside one access merges with the first and is lost
    if (TICK_1HZ) begin
      pending_d = 1'b1;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      pending_q  <= 1'b0;
      count_en_q <= 1'b0;
    end else begin
      pending_q  <= pending_d;
      count_en_q <= count_en_d;
    end
  end

  // leap year: bcd year divisible by four
  always_comb begin
    if (year_q[4]) begin
      leap = (year_q[3:0] == 4'h2) || (year_q[3:0] == 4'h6);
    end else begin
      leap = (year_q[3:0] == 4'h0) || (year_q[3:0] == 4'h4) ||
             (year_q[3:0] == 4'h8);
    end
  end

  // month and year counters plus host writes
  always_comb begin
    month_d = month_q;
    year_d  = year_q;
    // a carry that arrives while ACCESS_BUSY is high is dropped, not held over
    if (MONTH_CARRY && !ACCESS_BUSY) begin
      month_d = month_nxt[4:0];
      if (month_wrap) begin
        year_d = year_nxt;
      end
    end
    if (REG_WR) begin
      if (REG_ADDR == rtcca_pkg::ADDR_MONTH) begin
        month_d = REG_WDATA[4:0];
      end else if (REG_ADDR == rtcca_pkg::ADDR_YEAR) begin
        year_d = REG_WDATA;
      end
    end
  end

  // alarm registers
  always_comb begin
    sec_val_d              = sec_val_q;
    min_val_d              = min_val_q;
    hr_val_d               = hr_val_q;
    second_match_disable_d = second_match_disable_q;
    minute_match_disable_d = minute_match_disable_q;
    hour_match_disable_d   = hour_match_disable_q;
    if (REG_WR) begin
      if (REG_ADDR == rtcca_pkg::ADDR_SEC_AL) begin
        second_match_disable_d = REG_WDATA[rtcca_pkg::DISABLE_BIT];
        sec_val_d              = REG_WDATA[6:0];
      end else if (REG_ADDR == rtcca_pkg::ADDR_MIN_AL) begin
        minute_match_disable_d = REG_WDATA[rtcca_pkg::DISABLE_BIT];
        min_val_d              = REG_WDATA[6:0];
      end else if (REG_ADDR == rtcca_pkg::ADDR_HR_AL) begin
        hour_match_disable_d = REG_WDATA[rtcca_pkg::DISABLE_BIT];
        hr_val_d             = REG_WDATA[5:0];
      end
    end
  end

  // values keep their contents through SRST
  always_ff @(posedge CLOCK) begin
    month_q   <= month_d;
    year_q    <= year_d;
    sec_val_q <= sec_val_d;
    min_val_q <= min_val_d;
    hr_val_q  <= hr_val_d;
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      second_match_disable_q <= rtcca_pkg::DISABLE_RST;
      minute_match_disable_q <= rtcca_pkg::DISABLE_RST;
      hour_match_disable_q   <= rtcca_pkg::DISABLE_RST;
    end else begin
      second_match_disable_q <= second_match_disable_d;
      minute_match_disable_q <= minute_match_disable_d;
      hour_match_disable_q   <= hour_match_disable_d;
    end
  end

  // alarm field validity and comparison
  always_comb begin
    sec_ok = (sec_val_q[3:0] <= rtcca_pkg::UNITS_LAST) &&
             ({1'b0, sec_val_q} <= rtcca_pkg::SEC_LAST);
    min_ok = (min_val_q[3:0] <= rtcca_pkg::UNITS_LAST) &&
             ({1'b0, min_val_q} <= rtcca_pkg::SEC_LAST);
    if (HOUR_12_MODE) begin
      hr_ok = (hr_val_q[3:0] <= rtcca_pkg::UNITS_LAST) &&
              ({3'h0, hr_val_q[4:0]} <= rtcca_pkg::HOUR12_LAST) &&
              (hr_val_q[4:0] != 5'h00);
    end else begin
      hr_ok = (hr_val_q[3:0] <= rtcca_pkg::UNITS_LAST) &&
              ({2'h0, hr_val_q} <= rtcca_pkg::HOUR24_LAST);
    end
    // afternoon_select sits in bit 5 and compares as part of the field
    sec_hit = sec_ok && (sec_val_q == SECOND_NOW[6:0]);
    min_hit = min_ok && (min_val_q == MINUTE_NOW[6:0]);
    hr_hit  = hr_ok && (hr_val_q == HOUR_NOW[5:0]);
    any_enabled = !second_match_disable_q || !minute_match_disable_q ||
                  !hour_match_disable_q;
    full_match = any_enabled &&
                 (second_match_disable_q || sec_hit) &&
                 (minute_match_disable_q || min_hit) &&
                 (hour_match_disable_q || hr_hit);
  end

  // the time inputs settle one cycle after count enable, so the
  // compare is judged then; it fires once per increment only
  always_comb begin
    check_d      = count_en_q;
    match_flag_d = match_flag_q;
    if (FLAG_CLEAR) begin
      match_flag_d = 1'b0;
    end
    if (check_q && full_match) begin
      match_flag_d = 1'b1;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      check_q      <= 1'b0;
      match_flag_q <= 1'b0;
    end else begin
      check_q      <= check_d;
      match_flag_q <= match_flag_d;
    end
  end

  // register read data and month length
  always_comb begin
    rdata_d = 8'h00;
    if (REG_RD) begin
      if (REG_ADDR == rtcca_pkg::ADDR_MONTH) begin
        rdata_d = {3'h0, month_q} & rtcca_pkg::MASK_MONTH;
      end else if (REG_ADDR == rtcca_pkg::ADDR_YEAR) begin
        rdata_d = year_q & rtcca_pkg::MASK_YEAR;
      end else if (REG_ADDR == rtcca_pkg::ADDR_SEC_AL) begin
        rdata_d = {second_match_disable_q, sec_val_q} &
                  rtcca_pkg::MASK_SEC_AL;
      end else if (REG_ADDR == rtcca_pkg::ADDR_MIN_AL) begin
        rdata_d = {minute_match_disable_q, min_val_q} &
                  rtcca_pkg::MASK_MIN_AL;
      end else if (REG_ADDR == rtcca_pkg::ADDR_HR_AL) begin
        rdata_d = {hour_match_disable_q, 1'b0, hr_val_q} &
                  rtcca_pkg::MASK_HR_AL;
      end
    end
    case ({3'h0, month_q})
      rtcca_pkg::MONTH_FEB: days_d = leap ? rtcca_pkg::DAYS_29
                                          : rtcca_pkg::DAYS_28;
      8'h04, 8'h06, 8'h09, 8'h11: days_d = rtcca_pkg::DAYS_30;
      default: days_d = rtcca_pkg::DAYS_31;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      rdata_q <= 8'h00;
      days_q  <= rtcca_pkg::DAYS_31;
    end else begin
      rdata_q <= rdata_d;
      days_q  <= days_d;
    end
  end

  assign REG_RDATA     = rdata_q;
  assign COUNT_EN      = count_en_q;
  assign DAYS_IN_MONTH = days_q;
  assign MATCH_FLAG    = match_flag_q;
endmodule

//--- tb/rtcca_asserts.sv
// port-level assertions for the calendar, freeze and alarm block
module rtcca_asserts (
  input  wire logic       CLOCK,
  input  wire logic       SRST,
  input  wire logic       TICK_1HZ,
  input  wire logic       ACCESS_BUSY,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic       REG_RD,
  input  wire logic       FLAG_CLEAR,
  input  wire logic [7:0] REG_RDATA,
  input  wire logic       COUNT_EN,
  input  wire logic       MATCH_FLAG
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SRST);
  a_month_hi_zero:
    assert property (REG_RD && REG_ADDR == 8'h08 |=> REG_RDATA[7:5] == 3'h0)
    else $error("month upper bits not zero");
  a_hour_b6_zero:
    assert property (REG_RD && REG_ADDR == 8'h0c |=> !REG_RDATA[6])
    else $error("hour match bit 6 not zero");
  a_unmapped_zero:
    assert property (REG_RD && (REG_ADDR < 8'h08 || REG_ADDR > 8'h0c)
      |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_busy_freeze:
    assert property (ACCESS_BUSY |=> !COUNT_EN)
    else $error("increment during access");
  a_tick_served:
    assert property (TICK_1HZ ##1 !ACCESS_BUSY |=> COUNT_EN)
    else $error("tick not served");
  a_en_single:
    assert property (COUNT_EN |=> !COUNT_EN)
    else $error("increment longer than one cycle");
  a_flag_hold:
    assert property (MATCH_FLAG && !FLAG_CLEAR |=> MATCH_FLAG)
    else $error("flag dropped without clear");
  a_flag_cause:
    assert property ($rose(MATCH_FLAG) |-> $past(COUNT_EN, 2))
    else $error("flag set without increment");
  a_flag_clear:
    assert property (FLAG_CLEAR && !$past(COUNT_EN) |=> !MATCH_FLAG)
    else $error("flag not cleared");
endmodule

bind rtcca_top rtcca_asserts u_chk (.CLOCK, .SRST, .TICK_1HZ, .ACCESS_BUSY,
  .REG_ADDR, .REG_RD, .FLAG_CLEAR, .REG_RDATA, .COUNT_EN, .MATCH_FLAG);

//--- tb/rtcca_time_model.sv
// time counter chain model driving current second, minute and hour
module rtcca_time_model (
  input  wire logic       clk,
  input  wire logic       step,
  output logic      [7:0] sec,
  output logic      [7:0] min,
  output logic      [7:0] hour
);
  timeunit 1ns;
  timeprecision 1ns;
  // minute and hour stand still: a run lasts far below one minute
  assign min = 8'h30;
  assign hour = 8'h27;
  initial sec = 8'h00;
  // steps on the increment edge, as the compare timing expects
  always @(posedge clk)
    if (step === 1'h1) sec <= (sec == 8'h59) ? 8'h00 :
      (sec[3:0] == 4'h9) ? {sec[7:4] + 4'h1, 4'h0} : sec + 8'h01;
endmodule

//--- tb/tb_top.sv
// self-checking bench for the calendar, freeze and alarm block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       CLOCK = 1'h0, SRST = 1'h1, TICK_1HZ = 1'h0, REG_WR = 1'h0;
  logic       ACCESS_BUSY = 1'h0, REG_RD = 1'h0, MONTH_CARRY = 1'h0;
  logic       HOUR_12_MODE = 1'h0, FLAG_CLEAR = 1'h0, COUNT_EN, MATCH_FLAG;
  logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA, DAYS_IN_MONTH;
  logic [7:0] SECOND_NOW, MINUTE_NOW, HOUR_NOW, d, r, a;
  int         miscompares = 0, n_checks = 0, n_en = 0, i, y;
  rtcca_top u_dut (.CLOCK, .SRST, .TICK_1HZ, .ACCESS_BUSY, .REG_ADDR, .REG_WR,
    .REG_WDATA, .REG_RD, .MONTH_CARRY, .SECOND_NOW, .MINUTE_NOW, .HOUR_NOW,
    .HOUR_12_MODE, .FLAG_CLEAR, .REG_RDATA, .COUNT_EN, .DAYS_IN_MONTH,
    .MATCH_FLAG);
  rtcca_time_model u_tm (.clk(CLOCK), .step(COUNT_EN), .sec(SECOND_NOW),
    .min(MINUTE_NOW), .hour(HOUR_NOW));
  always #20 CLOCK = ~CLOCK;
  always @(posedge CLOCK) if (COUNT_EN === 1'h1) n_en <= n_en + 1;
  task automatic cyc(input int n);
    repeat (n) @(negedge CLOCK);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one idle edge after each strobe keeps back-to-back calls apart
  task automatic pulse(ref logic s);
    s = 1'h1;
    cyc(1);
    s = 1'h0;
    cyc(1);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] v);
    REG_ADDR = ad;
    REG_WDATA = v;
    pulse(REG_WR);
  endtask
  // read data stands for one cycle only, so it is taken before the gap
  task automatic rd(input logic [7:0] ad);
    REG_ADDR = ad;
    REG_RD = 1'h1;
    cyc(1);
    r = REG_RDATA;
    REG_RD = 1'h0;
    cyc(1);
  endtask
  task automatic alarm(input logic [7:0] exp);
    pulse(TICK_1HZ);
    cyc(5);
    chk({7'h0, MATCH_FLAG}, exp);
  endtask
  function automatic logic [7:0] nxt_s(input logic [7:0] s);
    if (s == 8'h59) return 8'h00;
    if (s[3:0] == 4'h9) return {s[7:4] + 4'h1, 4'h0};
    return s + 8'h01;
  endfunction
  function automatic logic [7:0] msk(input logic [7:0] ad);
    case (ad)
      8'h08: return rtcca_pkg::MASK_MONTH;
      8'h09: return rtcca_pkg::MASK_YEAR;
      8'h0a, 8'h0b: return rtcca_pkg::MASK_SEC_AL;
      8'h0c: return rtcca_pkg::MASK_HR_AL;
      default: return 8'h00;
    endcase
  endfunction
  initial begin
    #2ms;
    miscompares++;
    test_done;
  end
  initial begin
    void'($urandom(89272));
    cyc(8);
    SRST = 1'h0;
    cyc(1);
    for (i = 0; i < 24; i++) begin
      d = 8'($urandom);
      a = 8'h04 + 8'($urandom_range(3, 9));
      wr(a, d);
      rd(a);
      chk(r, d & msk(a));
    end
    wr(8'h08, 8'h07);
    for (i = 0; i < 3; i++) wr(8'h0a + 8'(i), 8'h15);
    pulse(SRST);
    rd(8'h08);
    chk(r, 8'h07);
    for (i = 0; i < 3; i++) begin
      rd(8'h0a + 8'(i));
      chk(r, 8'h95);
    end
    wr(8'h09, 8'h99);
    wr(8'h08, 8'h12);
    pulse(MONTH_CARRY);
    rd(8'h08);
    chk(r, 8'h01);
    rd(8'h09);
    chk(r, 8'h00);
    wr(8'h08, 8'h09);
    chk(DAYS_IN_MONTH, 8'h30);
    pulse(MONTH_CARRY);
    rd(8'h08);
    chk(r, 8'h10);
    chk(DAYS_IN_MONTH, 8'h31);
    wr(8'h08, 8'h02);
    for (i = 0; i < 6; i++) begin
      y = (i == 0) ? 0 : $urandom_range(0, 99);
      wr(8'h09, {4'(y / 10), 4'(y % 10)});
      cyc(1);
      chk(DAYS_IN_MONTH, (y % 4 == 0) ? 8'h29 : 8'h28);
    end
    // host access spans two ticks, so the second tick merges and is lost
    ACCESS_BUSY = 1'h1;
    y = n_en;
    pulse(TICK_1HZ);
    cyc(3);
    pulse(TICK_1HZ);
    pulse(MONTH_CARRY);
    cyc(3);
    chk(8'(n_en - y), 8'h00);
    rd(8'h08);
    chk(r, 8'h02);
    // year field set in the same access as the month read above
    wr(8'h09, 8'h24);
    rd(8'h09);
    chk(r, 8'h24);
    ACCESS_BUSY = 1'h0;
    cyc(4);
    chk(8'(n_en - y), 8'h01);
    chk(DAYS_IN_MONTH, 8'h29);
    wr(8'h0c, 8'h80);
    wr(8'h0b, 8'h31);
    wr(8'h0a, nxt_s(SECOND_NOW));
    alarm(8'h00);
    wr(8'h0b, 8'h80);
    wr(8'h0a, nxt_s(SECOND_NOW));
    alarm(8'h01);
    pulse(FLAG_CLEAR);
    alarm(8'h00);
    wr(8'h0a, 8'h80);
    HOUR_12_MODE = 1'h1;
    wr(8'h0c, 8'h27);
    alarm(8'h01);
    pulse(FLAG_CLEAR);
    HOUR_12_MODE = 1'h0;
    alarm(8'h00);
    test_done;
  end
endmodule
